// File: tuf_pkg.sv
// Behaviour
// [R1] Write splits each 30-bit word into five frames
// [R2] Unit adds parity and timing bit per frame
// [R3] Read packs five frames into one 30-bit word
// [R4] One command per block, except winds
// [R5] Blocks of one word upward, no limit
// [R6] Only selected unit moves data; winds anywhere
// [R7] At end of tape finish, wind, erase
// [R8] Host clears function register before manual use
// [R9] Words move at 1920 per second
// [R10] Most significant six bits go first
// [R11] Control word: unit, status flag, instruction
// [R12] Status request ignores instruction, disturbs nothing
// [R13] Reply: unit, operable, three-bit condition code
// [R14] Status request waits 265 us after motion; the unit here snapshots the reply at once, with no wait
package tuf_pkg;
   // Clock and transfer rates
   localparam int CLK_HZ = 50_000_000;
   localparam int WORD_RATE = 1920;
   localparam int FRAMES_PER_WORD = 5;
   localparam int FRAME_BITS = 6;
   localparam int WORD_BITS = 30;
   // Rounded down: word rate never undershot
   localparam int FRAME_CYC = CLK_HZ / (WORD_RATE * FRAMES_PER_WORD);
   // End-of-block condition stands for half the interblock space
   localparam int EOB_US = 8000;
   localparam int EOB_CYC = (CLK_HZ / 1_000_000) * EOB_US;
   // Register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // Control word fields
   localparam int CW_UNIT_LSB = 4;
   localparam int CW_STAT_BIT = 3;
   // Instruction codes
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_WIND_F = 3'h2;
   localparam logic [2:0] OP_WIND_B = 3'h3;
   localparam logic [2:0] OP_RD_BACK = 3'h5;
   // Condition codes of the status reply
   localparam logic [2:0] COND_READY = 3'h0;
   localparam logic [2:0] COND_WIND = 3'h1;
   localparam logic [2:0] COND_EOB = 3'h2;
   localparam logic [2:0] COND_FIRST = 3'h3;
   localparam logic [2:0] COND_EOT = 3'h4;
   localparam logic [2:0] COND_PARITY = 3'h5;
   // Interrupt status bits
   localparam int IRQ_N = 6;
   localparam int IRQ_WREQ = 0;
   localparam int IRQ_WRDY = 1;
   localparam int IRQ_EOB = 2;
   localparam int IRQ_PAR = 3;
   localparam int IRQ_EOT = 4;
   localparam int IRQ_REJ = 5;
   // Reset values
   localparam logic [5:0] STATUS_RST = 6'h00;
   localparam logic [5:0] MASK_RST = 6'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Unit states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_WRITE = 7'h02,
      ST_READ = 7'h04,
      ST_EOB = 7'h08,
      ST_WINDF = 7'h10,
      ST_WINDB = 7'h20,
      ST_EOTW = 7'h40
   } tuf_state_e;
endpackage

// File: tuf_ser.sv
`timescale 1ns/1ps
// Word to frame serialiser for the write head
module tuf_ser #(
   parameter int FB = 6,
   parameter int NF = 5
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [NF*FB-1:0] word,
   input wire logic tick,
   output logic [FB+1:0] frame,
   output logic frame_stb,
   output logic busy
);
   logic [NF*FB-1:0] sh_reg; // Word being sent
   logic [2:0] cnt_reg; // Frames left

   assign busy = (cnt_reg != 3'h0);

   // Load a word, then send one frame per tick, top bits first
   always_ff @(posedge clk) begin
      frame_stb <= 1'b0;
      if (!nrst) begin
         sh_reg <= '0;
         cnt_reg <= 3'h0;
         frame <= '0;
      end else if (load && !busy) begin
         sh_reg <= word;
         cnt_reg <= 3'(NF);
      end else if (tick && busy) begin
         // Timing bit set, odd parity
         frame <= {1'b1, ~^sh_reg[NF*FB-1 -: FB], sh_reg[NF*FB-1 -: FB]}; // [R2] [R10]
         frame_stb <= 1'b1;
         sh_reg <= {sh_reg[NF*FB-FB-1:0], {FB{1'b0}}}; // [R1]
         cnt_reg <= cnt_reg - 3'h1;
      end
   end
endmodule

// File: tuf_asm.sv
`timescale 1ns/1ps
// Frame to word assembler for the read head
module tuf_asm #(
   parameter int FB = 6,
   parameter int NF = 5
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic stb,
   input wire logic [FB+1:0] frame,
   output logic [NF*FB-1:0] word,
   output logic word_stb,
   output logic par_err
);
   logic [NF*FB-1:0] acc_reg; // Frames gathered so far
   logic [2:0] cnt_reg; // Frames in this word

   // First frame lands in the top bits
   always_ff @(posedge clk) begin
      word_stb <= 1'b0;
      par_err <= 1'b0;
      if (!nrst || clr) begin
         acc_reg <= '0;
         cnt_reg <= 3'h0;
         word <= '0;
      end else if (stb) begin
         // Odd parity over info and parity
         par_err <= ~^frame[FB:0];
         if (cnt_reg == 3'(NF - 1)) begin
            word <= {acc_reg[NF*FB-FB-1:0], frame[FB-1:0]}; // [R3] [R10]
            word_stb <= 1'b1;
            cnt_reg <= 3'h0;
         end else begin
            acc_reg <= {acc_reg[NF*FB-FB-1:0], frame[FB-1:0]};
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end
endmodule

// File: tuf_top.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Word framer, AXI4-Lite registers
module tuf_top #(
   parameter logic [1:0] UNIT_ID = 2'h0, // Unit number answered to
   parameter int FRAME_CYC = tuf_pkg::FRAME_CYC,
   parameter int EOB_CYC = tuf_pkg::EOB_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] tape_rd_frame,
   input wire logic tape_rd_stb,
   input wire logic tape_gap,
   input wire logic tape_eot_sw,
   input wire logic tape_out,
   input wire logic tape_bot,
   input wire logic tape_operable,
   output logic [7:0] tape_wr_frame,
   output logic tape_wr_stb,
   output logic mot_fwd,
   output logic mot_rev,
   output logic wr_gate,
   output logic erase,
   output logic irq
);
   localparam int WB = tuf_pkg::WORD_BITS;
   localparam int FB = tuf_pkg::FRAME_BITS;
   localparam int NF = tuf_pkg::FRAMES_PER_WORD;

   // Pin synchronisers
   logic [13:0] pin_s1_reg; // First stage, read only by second
   logic [13:0] pin_s2_reg; // Second stage, safe to use
   logic stb_d_reg; // Delayed strobe for edge detect
   logic [7:0] rd_frame;
   logic rd_stb_s, gap_s, eot_s, out_s, bot_s, oper_s;
   logic rd_edge;

   // Bus slave state
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] wmask;
   logic wr_fire, rd_fire;

   // Block state
   tuf_pkg::tuf_state_e state_reg;
   logic [2:0] op_reg; // Instruction being run
   logic [5:0] status_reg; // Last status reply
   logic [WB-1:0] wbuf_reg; // Word waiting for the head
   logic wbuf_full_reg;
   logic [WB-1:0] rbuf_reg; // Word waiting for the host
   logic rbuf_valid_reg;
   logic [31:0] div_reg; // Frame rate divider
   logic tick;
   logic [31:0] eob_cnt_reg; // End-of-block hold timer
   logic eot_pend_reg, par_seen_reg, got_frame_reg;
   logic [tuf_pkg::IRQ_N-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
   logic irq_reg, mot_fwd_reg, mot_rev_reg, wr_gate_reg, erase_reg;

   // Command decode
   logic [5:0] cw;
   logic cmd_wr, unit_hit, stat_req, mv_req, unit_ready, accept;
   logic [2:0] cond;
   logic [5:0] reply;
   logic ser_busy, ser_load, asm_wstb, asm_perr;
   logic [WB-1:0] asm_word;

   // Two flops per tape pin
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         stb_d_reg <= 1'b0;
      end else begin
         pin_s1_reg <= {tape_operable, tape_bot, tape_out, tape_eot_sw,
                        tape_gap, tape_rd_stb, tape_rd_frame};
         pin_s2_reg <= pin_s1_reg;
         stb_d_reg <= pin_s2_reg[8];
      end
   end

   assign rd_frame = pin_s2_reg[7:0];
   assign rd_stb_s = pin_s2_reg[8];
   assign gap_s = pin_s2_reg[9];
   assign eot_s = pin_s2_reg[10];
   assign out_s = pin_s2_reg[11];
   assign bot_s = pin_s2_reg[12];
   assign oper_s = pin_s2_reg[13];
   // Frames are taken only while this unit runs a read
   assign rd_edge = rd_stb_s && !stb_d_reg && (state_reg == tuf_pkg::ST_READ); // [R6]

   // Write address and data are latched in either order
   always_ff @(posedge clk) begin
      if (!nrst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= tuf_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_hold_reg <= 1'b1;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid && wready_reg) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_hold_reg <= 1'b1;
            wready_reg <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            // Unmapped: slave error
            case (aw_addr_reg)
               tuf_pkg::OFS_CMD, tuf_pkg::OFS_STATUS, tuf_pkg::OFS_WDATA,
               tuf_pkg::OFS_RDATA, tuf_pkg::OFS_FLAGS, tuf_pkg::OFS_IRQ_STAT,
               tuf_pkg::OFS_IRQ_MASK: bresp_reg <= tuf_pkg::RESP_OKAY;
               default: bresp_reg <= tuf_pkg::RESP_SLVERR;
            endcase
         end
         // Reopen after the response
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign rd_fire = s_axi_arvalid && arready_reg;

   // Read answered one cycle later
   always_ff @(posedge clk) begin
      if (!nrst) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= tuf_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= tuf_pkg::RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         case (s_axi_araddr)
            tuf_pkg::OFS_CMD: rdata_reg <= {26'h000_0000, cw};
            tuf_pkg::OFS_STATUS: rdata_reg <= {26'h000_0000, status_reg};
            tuf_pkg::OFS_WDATA: rdata_reg <= {2'h0, wbuf_reg};
            tuf_pkg::OFS_RDATA: rdata_reg <= {2'h0, rbuf_reg};
            tuf_pkg::OFS_FLAGS: rdata_reg <= {29'h0000_0000,
                                  state_reg != tuf_pkg::ST_IDLE, rbuf_valid_reg, wbuf_full_reg};
            tuf_pkg::OFS_IRQ_STAT: rdata_reg <= {26'h000_0000, irq_stat_reg};
            tuf_pkg::OFS_IRQ_MASK: rdata_reg <= {26'h000_0000, irq_mask_reg};
            default: rresp_reg <= tuf_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Control word fields: unit, status flag, instruction
   assign cw = w_data_reg[5:0]; // [R11]
   assign cmd_wr = wr_fire && (aw_addr_reg == tuf_pkg::OFS_CMD) && w_strb_reg[0];
   assign unit_hit = cw[tuf_pkg::CW_UNIT_LSB +: 2] == UNIT_ID; // [R6]
   assign stat_req = cmd_wr && unit_hit && cw[tuf_pkg::CW_STAT_BIT]; // [R12]
   assign mv_req = cmd_wr && unit_hit && !cw[tuf_pkg::CW_STAT_BIT]
                   && (cw[2:0] != tuf_pkg::OP_NONE);
   // Motion commands only between blocks
   assign unit_ready = (state_reg == tuf_pkg::ST_IDLE) || (state_reg == tuf_pkg::ST_EOB);
   assign accept = mv_req && unit_ready && oper_s; // [R4]

   // Condition code, most urgent first
   always_comb begin
      cond = tuf_pkg::COND_READY;
      case (state_reg)
         tuf_pkg::ST_EOTW: cond = tuf_pkg::COND_EOT;
         tuf_pkg::ST_WINDF, tuf_pkg::ST_WINDB: cond = tuf_pkg::COND_WIND;
         default: begin
            if (par_seen_reg) begin
               cond = tuf_pkg::COND_PARITY;
            end else if (state_reg == tuf_pkg::ST_EOB) begin
               cond = tuf_pkg::COND_EOB;
            end else if (bot_s) begin
               cond = tuf_pkg::COND_FIRST;
            end
         end
      endcase
   end
   assign reply = {UNIT_ID, oper_s, cond}; // [R13]

   // Reply snapshot on status request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_reg <= tuf_pkg::STATUS_RST;
      end else if (stat_req) begin
         status_reg <= reply; // [R12]
      end
   end

   // Frame tick, writes only
   always_ff @(posedge clk) begin
      if (!nrst || accept || state_reg != tuf_pkg::ST_WRITE) begin
         div_reg <= 32'h0000_0000;
      end else if (tick) begin
         div_reg <= 32'h0000_0000;
      end else begin
         div_reg <= div_reg + 32'h0000_0001;
      end
   end
   assign tick = div_reg == 32'(FRAME_CYC - 1); // [R9]

   // Word for the head; refilled while one is sent
   assign ser_load = wbuf_full_reg && !ser_busy && (state_reg == tuf_pkg::ST_WRITE);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wbuf_reg <= '0;
         wbuf_full_reg <= 1'b0;
      end else if (wr_fire && aw_addr_reg == tuf_pkg::OFS_WDATA) begin
         wbuf_reg <= (wbuf_reg & ~wmask[WB-1:0]) | (w_data_reg[WB-1:0] & wmask[WB-1:0]);
         wbuf_full_reg <= 1'b1;
      end else if (ser_load) begin
         wbuf_full_reg <= 1'b0;
      end
   end

   // Word buffer toward the host; reading it frees it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rbuf_reg <= '0;
         rbuf_valid_reg <= 1'b0;
      end else if (asm_wstb) begin
         rbuf_reg <= asm_word; // [R3]
         rbuf_valid_reg <= 1'b1;
      end else if (rd_fire && s_axi_araddr == tuf_pkg::OFS_RDATA) begin
         rbuf_valid_reg <= 1'b0;
      end
   end

   // Flags, cleared per accepted command
   always_ff @(posedge clk) begin
      if (!nrst || accept) begin
         par_seen_reg <= 1'b0;
         got_frame_reg <= 1'b0;
         eot_pend_reg <= 1'b0;
      end else begin
         if (asm_perr) begin
            par_seen_reg <= 1'b1;
         end
         if (rd_edge) begin
            got_frame_reg <= 1'b1;
         end
         // End of tape counts on forward data moves
         if (eot_s && (state_reg == tuf_pkg::ST_WRITE ||
             (state_reg == tuf_pkg::ST_READ && op_reg != tuf_pkg::OP_RD_BACK))) begin
            eot_pend_reg <= 1'b1; // [R7]
         end
      end
   end

   // Unit sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= tuf_pkg::ST_IDLE;
         op_reg <= tuf_pkg::OP_NONE;
         eob_cnt_reg <= 32'h0000_0000;
      end else if (accept) begin
         op_reg <= cw[2:0];
         case (cw[2:0])
            tuf_pkg::OP_WRITE: state_reg <= tuf_pkg::ST_WRITE;
            // Winds run on without per-block commands
            tuf_pkg::OP_WIND_F: state_reg <= tuf_pkg::ST_WINDF; // [R4]
            tuf_pkg::OP_WIND_B: state_reg <= tuf_pkg::ST_WINDB;
            default: state_reg <= tuf_pkg::ST_READ;
         endcase
      end else if (!oper_s && state_reg != tuf_pkg::ST_IDLE) begin
         // A unit that drops out stops dead
         state_reg <= tuf_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            tuf_pkg::ST_IDLE: state_reg <= tuf_pkg::ST_IDLE;
            tuf_pkg::ST_WRITE: begin
               // Block ends at a tick with no word
               if (tick && !ser_busy && !wbuf_full_reg) begin // [R5]
                  eob_cnt_reg <= 32'h0000_0000;
                  state_reg <= eot_pend_reg ? tuf_pkg::ST_EOTW : tuf_pkg::ST_EOB; // [R7]
               end
            end
            tuf_pkg::ST_READ: begin
               // Ignore the gap the tape starts in
               if (gap_s && got_frame_reg) begin
                  eob_cnt_reg <= 32'h0000_0000;
                  state_reg <= eot_pend_reg ? tuf_pkg::ST_EOTW : tuf_pkg::ST_EOB; // [R7]
               end
            end
            tuf_pkg::ST_EOB: begin
               if (eob_cnt_reg == 32'(EOB_CYC - 1)) begin
                  state_reg <= tuf_pkg::ST_IDLE;
               end else begin
                  eob_cnt_reg <= eob_cnt_reg + 32'h0000_0001;
               end
            end
            tuf_pkg::ST_WINDF, tuf_pkg::ST_EOTW: begin
               if (out_s) begin
                  state_reg <= tuf_pkg::ST_IDLE; // [R7]
               end
            end
            tuf_pkg::ST_WINDB: begin
               if (bot_s) begin
                  state_reg <= tuf_pkg::ST_IDLE;
               end
            end
            default: state_reg <= tuf_pkg::ST_IDLE;
         endcase
      end
   end

   // Head and motor drives follow the state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mot_fwd_reg <= 1'b0;
         mot_rev_reg <= 1'b0;
         wr_gate_reg <= 1'b0;
         erase_reg <= 1'b0;
      end else begin
         mot_fwd_reg <= (state_reg == tuf_pkg::ST_WRITE) || (state_reg == tuf_pkg::ST_WINDF)
                        || (state_reg == tuf_pkg::ST_EOTW)
                        || (state_reg == tuf_pkg::ST_READ && op_reg != tuf_pkg::OP_RD_BACK);
         mot_rev_reg <= (state_reg == tuf_pkg::ST_WINDB)
                        || (state_reg == tuf_pkg::ST_READ && op_reg == tuf_pkg::OP_RD_BACK);
         wr_gate_reg <= state_reg == tuf_pkg::ST_WRITE;
         // Erase stays on through the end-of-tape wind
         erase_reg <= (state_reg == tuf_pkg::ST_WRITE) || (state_reg == tuf_pkg::ST_EOTW); // [R7]
      end
   end

   // Events for the interrupt status register
   always_comb begin
      irq_ev = '0;
      irq_ev[tuf_pkg::IRQ_WREQ] = ser_load;
      irq_ev[tuf_pkg::IRQ_WRDY] = asm_wstb;
      // Same conditions that end a block in the sequencer
      irq_ev[tuf_pkg::IRQ_EOB] = (state_reg == tuf_pkg::ST_WRITE && tick && !ser_busy && !wbuf_full_reg)
                                 || (state_reg == tuf_pkg::ST_READ && gap_s && got_frame_reg);
      irq_ev[tuf_pkg::IRQ_PAR] = asm_perr;
      irq_ev[tuf_pkg::IRQ_EOT] = (state_reg == tuf_pkg::ST_EOTW) && out_s;
      irq_ev[tuf_pkg::IRQ_REJ] = mv_req && !accept;
   end

   // Sticky, write one to clear; set beats clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= tuf_pkg::MASK_RST;
         irq_reg <= 1'b0;
      end else begin
         if (wr_fire && aw_addr_reg == tuf_pkg::OFS_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~(w_data_reg[5:0] & wmask[5:0])) | irq_ev;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
         end
         if (wr_fire && aw_addr_reg == tuf_pkg::OFS_IRQ_MASK && w_strb_reg[0]) begin
            irq_mask_reg <= w_data_reg[5:0];
         end
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   tuf_ser #(.FB(FB), .NF(NF)) u_ser (
      .clk(clk),
      .nrst(nrst),
      .load(ser_load),
      .word(wbuf_reg),
      .tick(tick),
      .frame(tape_wr_frame),
      .frame_stb(tape_wr_stb),
      .busy(ser_busy)
   );

   tuf_asm #(.FB(FB), .NF(NF)) u_asm (
      .clk(clk),
      .nrst(nrst),
      .clr(accept),
      .stb(rd_edge),
      .frame(rd_frame),
      .word(asm_word),
      .word_stb(asm_wstb),
      .par_err(asm_perr)
   );

   // Outputs straight from their flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign mot_fwd = mot_fwd_reg;
   assign mot_rev = mot_rev_reg;
   assign wr_gate = wr_gate_reg;
   assign erase = erase_reg;
   assign irq = irq_reg;
endmodule

// File: tuf_top_assertions.sv
`timescale 1ns/1ps
// Bus and write head checks
module tuf_chk (
   input wire logic clk, nrst,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [7:0] tape_wr_frame,
   input wire logic tape_wr_stb, erase, mot_fwd, mot_rev, wr_gate
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // One frame slot at FRAME_CYC 8
   sequence quiet_slot;
      !tape_wr_stb [*7];
   endsequence
   // Address and data taken on one edge
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_stb_slot: assert property (tape_wr_stb |=> quiet_slot)
      else $error("strobes too close");
   a_timing_bit: assert property (tape_wr_stb |-> tape_wr_frame[7])
      else $error("no timing bit");
   a_odd_parity: assert property (tape_wr_stb |-> ^tape_wr_frame[6:0])
      else $error("even parity");
   a_stb_moving: assert property (tape_wr_stb |-> mot_fwd && wr_gate)
      else $error("write while stopped");
   a_erase_fwd: assert property (erase |-> mot_fwd && !mot_rev)
      else $error("stray erase");
   a_b_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
      else $error("late bvalid");
   a_b_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("early ready");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("late rvalid");
endmodule
bind tuf_top tuf_chk tuf_chk_i (.*);

// File: tuf_tape.sv
`timescale 1ns/1ps
// Tape transport and read head
module tuf_tape (
   input wire logic clk,
   output logic [7:0] tape_rd_frame,
   output logic tape_rd_stb, tape_gap, tape_eot_sw, tape_out, tape_bot, tape_operable
);
   // Parked in a gap, operable
   initial begin
      tape_rd_frame = 8'h00;
      tape_rd_stb = 1'h0;
      tape_gap = 1'h1;
      {tape_eot_sw, tape_out, tape_bot} = 3'h0;
      tape_operable = 1'h1;
   end
   // One word; bad flips parity
   task automatic send_word(input logic [29:0] w, input logic bad);
      logic [5:0] c;
      tape_gap <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         c = w[29-6*i -: 6];
         tape_rd_frame <= {1'h1, ~^c ^ bad, c};
         repeat (4) @(posedge clk);
         tape_rd_stb <= 1'h1;
         repeat (4) @(posedge clk);
         tape_rd_stb <= 1'h0;
         repeat (4) @(posedge clk);
         // Stale data inverted
         tape_rd_frame <= ~tape_rd_frame;
         repeat (2) @(posedge clk);
      end
      tape_gap <= 1'h1;
   endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// Bench for the framer
module tb;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tape_rd_frame, tape_wr_frame;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic tape_rd_stb, tape_gap, tape_eot_sw, tape_out, tape_bot, tape_operable;
   logic tape_wr_stb, mot_fwd, mot_rev, wr_gate, erase, irq;
   logic [31:0] seed = 32'ha0b4_5a31;
   logic [29:0] w;
   int fail_count = 0, tests_run = 0, cyc = 0, n;
   tuf_top #(.FRAME_CYC(8), .EOB_CYC(20)) tuf_top_i (.*);
   tuf_tape tuf_tape_i (.*);
   always #10 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected head frame
   function automatic logic [7:0] frm(input logic [29:0] x, input int i);
      logic [5:0] c;
      c = x[29-6*i -: 6];
      return {1'h1, ~^c, c};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      {ad, wd} = 2'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (s_axi_awready && !ad) begin
            ad = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wready && !wd) begin
            wd = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      s_axi_bready <= 1'h1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      wr(8'h00, 32'h0);
      rd(tuf_pkg::OFS_IRQ_MASK);
      chk("mask reset", 0, d);
      rd(8'h1c);
      chk("unmapped resp", tuf_pkg::RESP_SLVERR, rs);
      wr(tuf_pkg::OFS_IRQ_MASK, 32'h3f);
      $display("test registers done");
      // One-word writes, random then all ones
      for (int k = 0; k < 2; k++) begin
         d = rnd();
         w = k ? 30'h3fff_ffff : d[29:0];
         wr(tuf_pkg::OFS_WDATA, {2'h0, w});
         wr(tuf_pkg::OFS_CMD, {29'h0, tuf_pkg::OP_WRITE});
         for (int i = 0; i < 5; i++) begin
            n = 0;
            do begin @(posedge clk); n++; end while (!tape_wr_stb);
            chk("frame", frm(w, i), tape_wr_frame);
            if (i > 0) chk("frame spacing", 8, n);
         end
         do rd(tuf_pkg::OFS_IRQ_STAT); while (!d[tuf_pkg::IRQ_EOB]);
         chk("irq raised", 1, irq);
         wr(tuf_pkg::OFS_IRQ_STAT, 32'h3f);
         @(posedge clk);
         chk("irq cleared", 0, irq);
         repeat (25) @(posedge clk);
      end
      $display("test write done");
      // Read, parity fault, status request
      d = rnd();
      w = d[29:0];
      wr(tuf_pkg::OFS_CMD, 32'h4);
      tuf_tape_i.send_word(w, 1'h0);
      rd(tuf_pkg::OFS_RDATA);
      chk("read word", {2'h0, w}, d);
      repeat (30) @(posedge clk);
      wr(tuf_pkg::OFS_CMD, 32'h4);
      tuf_tape_i.send_word(w, 1'h1);
      repeat (13250) @(posedge clk);
      wr(tuf_pkg::OFS_CMD, 32'hf);
      rd(tuf_pkg::OFS_STATUS);
      chk("status reply", 32'hd, d);
      wr(tuf_pkg::OFS_CMD, 32'h11);
      repeat (4) @(posedge clk);
      rd(tuf_pkg::OFS_FLAGS);
      chk("other unit idle", 0, d[2]);
      $display("test read done");
      // End of tape during a read
      wr(tuf_pkg::OFS_IRQ_MASK, 32'h0);
      tuf_tape_i.tape_eot_sw <= 1'h1;
      wr(tuf_pkg::OFS_CMD, 32'h4);
      tuf_tape_i.send_word(w, 1'h0);
      while (!erase) @(posedge clk);
      chk("wind forward", 1, mot_fwd);
      tuf_tape_i.tape_out <= 1'h1;
      do rd(tuf_pkg::OFS_IRQ_STAT); while (!d[tuf_pkg::IRQ_EOT]);
      chk("erase stops", 0, erase);
      chk("masked irq", 0, irq);
      $display("test end of tape done");
      close_out();
   end
endmodule
